/* fio_dec_if.sv */
// Address and decode result between router and fixed range decoder
`timescale 1ns/1ps
`default_nettype none
interface fio_dec_if;
    import fio_pkg::*;
    logic [15:0] addr;
    logic wr;
    logic hit;
    logic rsv;
    fio_unit_t unit;
    modport req (output addr, output wr, input hit, input rsv, input unit);
    modport dec (input addr, input wr, output hit, output rsv, output unit);
endinterface
`default_nettype wire

/* fio_fixed_dec.sv */
// Fixed legacy I/O range decoder, split by direction
`timescale 1ns/1ps
`default_nettype none
module fio_fixed_dec (
    // Decode request and result
    fio_dec_if.dec dec
);
    import fio_pkg::*;

    logic [7:0] lo;

    assign lo = dec.addr[7:0];

    // Map the low page onto units; rsv marks a location reserved for this direction
    always_comb begin
        dec.hit = 1'b0;
        dec.rsv = 1'b0;
        dec.unit = U_NONE;
        if (dec.addr[15:8] == IO_PAGE_LEGACY) begin
            if (lo <= DMA_TOP) begin
                if (lo[3:0] <= DMA_RW_LAST || lo[3:0] == DMA_RW_TAIL || dec.wr) begin
                    dec.hit = 1'b1;
                    dec.unit = U_DMA;
                end else begin
                    dec.rsv = 1'b1;
                end
            end else if (lo[7:1] == SUPER_IO_A[7:1] || lo[7:1] == SUPER_IO_B[7:1]) begin
                dec.hit = 1'b1;
                dec.unit = U_LPC;
            end else if (lo >= INTC_LO && lo <= INTC_HI) begin
                if (!lo[1]) begin
                    dec.hit = 1'b1;
                    dec.unit = U_INTC;
                end
            end else if (lo[7:4] == TMR_A || lo[7:4] == TMR_B) begin
                if (lo[3:2] == 2'b00) begin
                    if (lo[1:0] != TMR_CTRL || dec.wr) begin
                        dec.hit = 1'b1;
                        dec.unit = U_TMR;
                    end else begin
                        dec.rsv = 1'b1;
                    end
                end
            end else if (lo[7:3] == KBC_BASE[7:3]) begin
                dec.hit = 1'b1;
                dec.unit = lo[0] ? U_NMI : U_LPC;
            end else if (lo >= RTC_LO && lo <= RTC_HI) begin
                if (dec.wr && !lo[0]) begin
                    dec.hit = 1'b1;
                    dec.unit = U_NMI_RTC;
                end else if (!dec.wr && lo == RTC_LO) begin
                    dec.rsv = 1'b1;
                end else begin
                    dec.hit = 1'b1;
                    dec.unit = U_RTC;
                end
            end
        end
    end

endmodule
`default_nettype wire

/* fio_host_model.sv */
// Host side model that issues I/O and configuration cycles
`timescale 1ns/1ps
`default_nettype none
module fio_host_model (
    // Clock
    input wire logic clk_sys,
    // I/O cycle
    output logic io_valid,
    output fio_pkg::fio_src_t io_src,
    output logic io_write,
    output logic [15:0] io_addr,
    output logic [7:0] io_wdata,
    // Configuration cycle
    output logic cfg_valid,
    output logic cfg_write,
    output logic [7:0] cfg_bus,
    output logic [4:0] cfg_dev,
    output logic [2:0] cfg_func,
    output logic [7:0] cfg_reg,
    output logic [31:0] cfg_wdata
);
    import fio_pkg::*;
    ////////////////////////////////////////////////////////////////////////////
    // One request slot per falling edge; address fields of an idle slot carry random junk
    task automatic drive(input logic iv, input fio_src_t s, input logic w, input logic [15:0] a,
        input logic [7:0] d, input logic cv, input logic cw, input logic [7:0] b,
        input logic [4:0] dv, input logic [2:0] f, input logic [7:0] r, input logic [31:0] wd);
        @(negedge clk_sys);
        {io_valid, io_write, cfg_valid, cfg_write} = {iv, w, cv, cw};
        io_src = s;
        io_addr = iv ? a : 16'($urandom);
        io_wdata = d;
        {cfg_bus, cfg_dev, cfg_func, cfg_reg} = cv ? {b, dv, f, r} : 24'($urandom);
        cfg_wdata = wd;
    endtask
    // Quiet request lines at time zero
    initial begin
        {io_valid, io_write, cfg_valid, cfg_write} = 4'h0;
        io_src = SRC_HUB;
        {io_addr, io_wdata, cfg_bus, cfg_dev, cfg_func, cfg_reg, cfg_wdata} = 80'h0;
    end
endmodule
`default_nettype wire

/* fio_pkg.sv */
// Shared constants and types of the fixed I/O decode router
`default_nettype none
package fio_pkg;

    // Target unit of a routed I/O cycle
    typedef enum logic [3:0] {
        U_NONE    = 4'h0,
        U_DMA     = 4'h1,
        U_TMR     = 4'h3,
        U_INTC    = 4'h2,
        U_LPC     = 4'h6,
        U_NMI     = 4'h7,
        U_NMI_RTC = 4'h5,
        U_RTC     = 4'h4,
        U_PCI     = 4'hC
    } fio_unit_t;

    // Origin of an I/O cycle
    typedef enum logic {
        SRC_HUB = 1'b0,
        SRC_PCI = 1'b1
    } fio_src_t;

    ////////////////////////////////////////////////////////////////////////////
    // Fixed I/O map: legacy page in the high byte, then locations in the low byte of the address
    localparam logic [7:0] IO_PAGE_LEGACY = 8'h00;
    localparam logic [7:0] DMA_TOP = 8'h1F;
    localparam logic [3:0] DMA_RW_LAST = 4'h8;
    localparam logic [3:0] DMA_RW_TAIL = 4'hF;
    localparam logic [7:0] INTC_LO = 8'h20;
    localparam logic [7:0] INTC_HI = 8'h3D;
    localparam logic [7:0] SUPER_IO_A = 8'h2E;
    localparam logic [7:0] SUPER_IO_B = 8'h4E;
    localparam logic [3:0] TMR_A = 4'h4;
    localparam logic [3:0] TMR_B = 4'h5;
    localparam logic [1:0] TMR_CTRL = 2'h3;
    localparam logic [7:0] KBC_BASE = 8'h60;
    localparam logic [7:0] RTC_LO = 8'h70;
    localparam logic [7:0] RTC_HI = 8'h74;

    ////////////////////////////////////////////////////////////////////////////
    // Configuration space
    localparam logic [7:0] BUS_PRIMARY = 8'h00;
    localparam logic [7:0] BUS_SECONDARY = 8'h01;
    localparam logic [4:0] DEV_HUB_PCI = 5'h1E;
    localparam logic [4:0] DEV_LEGACY = 5'h1F;
    localparam logic [4:0] DEV_LAN = 5'h08;
    localparam logic [2:0] FUNC_BASE = 3'h0;
    localparam logic [2:0] FUNC_OPT_LAST = 3'h6;
    localparam int NUM_OPT_FUNC = 6;
    localparam logic [7:0] CFG_ID_OFF = 8'h00;
    localparam logic [7:0] CFG_DSTAT_OFF = 8'h40;
    localparam logic [7:0] CFG_SHARED_OFF = 8'h44;
    localparam logic [31:0] CFG_ABSENT_DATA = 32'hFFFFFFFF;
    // Arbitrary identity values
    localparam logic [15:0] ID_VENDOR = 16'h1234;
    localparam logic [7:0] ID_DEVICE_HI = 8'hA5;

    ////////////////////////////////////////////////////////////////////////////
    // Decode status bits and reset values
    localparam int STAT_RSV_PASS = 0;
    localparam int STAT_NO_DECODE = 1;
    localparam logic [1:0] STAT_RESET = 2'h0;
    localparam logic [11:0] VAR_BASE_RESET = 12'h000;
    localparam logic [15:0] CNT_RESET = 16'h0000;
    localparam logic [15:0] CNT_STEP = 16'h0001;
    localparam int VAR_EN_BIT = 0;

endpackage
`default_nettype wire

/* fio_router.sv */
// Fixed I/O decode router with configuration function presence
`timescale 1ns/1ps
`default_nettype none
module fio_router #(
    parameter logic [7:0] SEC_BUS = fio_pkg::BUS_SECONDARY
) (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic reset_n,
    // I/O cycle request
    input wire logic io_valid,
    input wire fio_pkg::fio_src_t io_src,
    input wire logic io_write,
    input wire logic [15:0] io_addr,
    input wire logic [7:0] io_wdata,
    // Routed cycle
    output logic rt_valid,
    output fio_pkg::fio_unit_t rt_unit,
    output logic rt_sel_int,
    output logic rt_sel_lpc,
    output logic rt_sel_pci,
    output logic rt_claim_medium,
    output logic rt_write,
    output logic [15:0] rt_addr,
    output logic [7:0] rt_wdata,
    // Configuration cycle
    input wire logic cfg_valid,
    input wire logic cfg_write,
    input wire logic [7:0] cfg_bus,
    input wire logic [4:0] cfg_dev,
    input wire logic [2:0] cfg_func,
    input wire logic [7:0] cfg_reg,
    input wire logic [31:0] cfg_wdata,
    output logic cfg_done,
    output logic cfg_claim,
    output logic [31:0] cfg_rdata,
    // Platform
    input wire logic [fio_pkg::NUM_OPT_FUNC-1:0] func_disable,
    input wire logic lan_present
);
    import fio_pkg::*;

    fio_dec_if dec_bus ();

    logic lan_meta_ff;
    logic lan_sync_ff;
    logic var_en_ff;
    logic [11:0] var_base_ff;
    logic [1:0] stat_ff;
    logic [15:0] claim_cnt_ff;
    logic var_hit;
    logic nxt_take;
    fio_unit_t nxt_unit;
    logic nxt_int;
    logic nxt_lpc;
    logic nxt_pci;
    logic nxt_med;
    logic ev_rsv;
    logic ev_nodec;
    logic present;
    logic is_lpcb;
    logic wr_stat;
    logic wr_shared;
    logic [31:0] rd_val;
    logic [1:0] nxt_stat;

    // Presence of a function in configuration space
    function automatic logic func_present(input logic [7:0] bus, input logic [4:0] dev,
                                          input logic [2:0] func,
                                          input logic [NUM_OPT_FUNC-1:0] dis,
                                          input logic lan);
        logic ok;
        ok = 1'b0;
        if (bus == BUS_PRIMARY && dev == DEV_HUB_PCI && func == FUNC_BASE) begin
            ok = 1'b1;
        end else if (bus == BUS_PRIMARY && dev == DEV_LEGACY) begin
            if (func == FUNC_BASE) begin
                ok = 1'b1;
            end else if (func <= FUNC_OPT_LAST) begin
                ok = !dis[func - 3'h1];
            end
        end else if (bus == SEC_BUS && dev == DEV_LAN && func == FUNC_BASE) begin
            ok = lan;
        end
        return ok;
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // Network connect detect pin synchroniser
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            lan_meta_ff <= 1'b0;
            lan_sync_ff <= 1'b0;
        end else begin
            lan_meta_ff <= lan_present;
            lan_sync_ff <= lan_meta_ff;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Fixed range decode and target choice
    assign dec_bus.addr = io_addr;
    assign dec_bus.wr = io_write;

    fio_fixed_dec u_dec (
        .dec(dec_bus)
    );

    assign var_hit = var_en_ff && (io_addr[15:4] == var_base_ff);

    // One target per accepted cycle; PCI masters only see positive decode
    always_comb begin
        nxt_take = 1'b0;
        nxt_unit = U_NONE;
        nxt_int = 1'b0;
        nxt_lpc = 1'b0;
        nxt_pci = 1'b0;
        nxt_med = 1'b0;
        if (io_valid) begin
            if (dec_bus.hit) begin
                nxt_take = 1'b1;
                nxt_unit = dec_bus.unit;
                nxt_lpc = (dec_bus.unit == U_LPC);
                nxt_int = (dec_bus.unit != U_LPC);
                nxt_med = (io_src == SRC_PCI);
            end else if (var_hit) begin
                nxt_take = 1'b1;
                nxt_unit = U_LPC;
                nxt_lpc = 1'b1;
                nxt_med = (io_src == SRC_PCI);
            end else if (io_src == SRC_HUB) begin
                nxt_take = 1'b1;
                nxt_unit = U_PCI;
                nxt_pci = 1'b1;
            end
        end
    end

    // Routed cycle outputs, one cycle after the request
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            rt_valid <= 1'b0;
            rt_unit <= U_NONE;
            rt_sel_int <= 1'b0;
            rt_sel_lpc <= 1'b0;
            rt_sel_pci <= 1'b0;
            rt_claim_medium <= 1'b0;
            rt_write <= 1'b0;
            rt_addr <= 16'h0000;
            rt_wdata <= 8'h00;
        end else begin
            rt_valid <= nxt_take;
            rt_unit <= nxt_unit;
            rt_sel_int <= nxt_int;
            rt_sel_lpc <= nxt_lpc;
            rt_sel_pci <= nxt_pci;
            rt_claim_medium <= nxt_med;
            rt_write <= io_valid && io_write;
            rt_addr <= io_valid ? io_addr : 16'h0000;
            rt_wdata <= (io_valid && io_write) ? io_wdata : 8'h00;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Configuration access decode
    assign present = cfg_valid &&
                     func_present(cfg_bus, cfg_dev, cfg_func, func_disable, lan_sync_ff);
    assign is_lpcb = present && cfg_bus == BUS_PRIMARY && cfg_dev == DEV_LEGACY &&
                     cfg_func == FUNC_BASE;
    assign wr_stat = is_lpcb && cfg_write && cfg_reg == CFG_DSTAT_OFF;
    assign wr_shared = is_lpcb && cfg_write && cfg_reg == CFG_SHARED_OFF;

    // Read side of each implemented location
    always_comb begin
        rd_val = 32'h00000000;
        if (cfg_reg == CFG_ID_OFF) begin
            rd_val = {ID_DEVICE_HI, cfg_dev, cfg_func, ID_VENDOR};
        end else if (is_lpcb && cfg_reg == CFG_DSTAT_OFF) begin
            rd_val = {30'h00000000, stat_ff};
        end else if (is_lpcb && cfg_reg == CFG_SHARED_OFF) begin
            rd_val = {16'h0000, claim_cnt_ff};
        end
    end

    // Configuration answer; an absent function never claims
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            cfg_done <= 1'b0;
            cfg_claim <= 1'b0;
            cfg_rdata <= 32'h00000000;
        end else begin
            cfg_done <= cfg_valid;
            cfg_claim <= present;
            if (cfg_valid && !cfg_write) begin
                cfg_rdata <= present ? rd_val : CFG_ABSENT_DATA;
            end else begin
                cfg_rdata <= 32'h00000000;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Write side of the shared location: variable LPC window
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            var_en_ff <= 1'b0;
            var_base_ff <= VAR_BASE_RESET;
        end else if (wr_shared) begin
            var_en_ff <= cfg_wdata[VAR_EN_BIT];
            var_base_ff <= cfg_wdata[15:4];
        end
    end

    // Read side of the shared location: internal claim count
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            claim_cnt_ff <= CNT_RESET;
        end else if (nxt_int) begin
            claim_cnt_ff <= claim_cnt_ff + CNT_STEP;
        end
    end

    // Sticky decode status; a new event wins over a clear in the same cycle
    assign ev_rsv = io_valid && io_src == SRC_HUB && dec_bus.rsv && !var_hit;
    assign ev_nodec = io_valid && !dec_bus.hit && !dec_bus.rsv && !var_hit;

    always_comb begin
        nxt_stat = stat_ff;
        if (wr_stat) begin
            nxt_stat = stat_ff & ~cfg_wdata[1:0];
        end
        nxt_stat[STAT_RSV_PASS] = nxt_stat[STAT_RSV_PASS] | ev_rsv;
        nxt_stat[STAT_NO_DECODE] = nxt_stat[STAT_NO_DECODE] | ev_nodec;
    end

    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            stat_ff <= STAT_RESET;
        end else begin
            stat_ff <= nxt_stat;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Checks
    logic rst_seen_ff;

    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            rst_seen_ff <= 1'b0;
        end else begin
            rst_seen_ff <= 1'b1;
        end
    end

    AST_W1C_CLEAR: assert property (@(posedge clk_sys) disable iff (!reset_n)
        wr_stat && cfg_wdata[STAT_RSV_PASS] && !ev_rsv |=> !stat_ff[STAT_RSV_PASS])
        else $error("status bit not cleared by write of one");
    AST_W1C_KEEP: assert property (@(posedge clk_sys) disable iff (!reset_n)
        wr_stat && !cfg_wdata[STAT_NO_DECODE] && stat_ff[STAT_NO_DECODE]
        |=> stat_ff[STAT_NO_DECODE])
        else $error("status bit lost on write of zero");
    AST_RESET_DEFAULT: assert property (@(posedge clk_sys) disable iff (!reset_n)
        !rst_seen_ff |-> !var_en_ff && stat_ff == STAT_RESET && claim_cnt_ff == CNT_RESET)
        else $error("register not at default after reset");
    AST_SHARED_RD: assert property (@(posedge clk_sys) disable iff (!reset_n)
        is_lpcb && !cfg_write && cfg_reg == CFG_SHARED_OFF
        |=> cfg_rdata == {16'h0000, $past(claim_cnt_ff)})
        else $error("shared read did not return claim count");
    AST_SHARED_WR: assert property (@(posedge clk_sys) disable iff (!reset_n)
        wr_shared |=> var_base_ff == $past(cfg_wdata[15:4]) && var_en_ff == $past(cfg_wdata[0]))
        else $error("shared write did not reach window register");
    AST_FUNC_OFF: assert property (@(posedge clk_sys) disable iff (!reset_n)
        cfg_valid && cfg_bus == BUS_PRIMARY && cfg_dev == DEV_LEGACY && cfg_func != FUNC_BASE &&
        cfg_func <= FUNC_OPT_LAST && func_disable[cfg_func - 3'h1]
        |=> cfg_done && !cfg_claim)
        else $error("disabled function claimed a configuration cycle");
    AST_LAN_ABSENT: assert property (@(posedge clk_sys) disable iff (!reset_n)
        cfg_valid && !lan_sync_ff && cfg_bus == SEC_BUS && cfg_dev == DEV_LAN |=> !cfg_claim)
        else $error("network function visible without connect component");
    AST_CFG_ONLY: assert property (@(posedge clk_sys) disable iff (!reset_n)
        cfg_claim |-> cfg_done && $past(cfg_valid))
        else $error("claim without configuration cycle");
    AST_RSV_TO_PCI: assert property (@(posedge clk_sys) disable iff (!reset_n)
        io_valid && io_src == SRC_HUB && dec_bus.rsv && !var_hit
        |=> rt_valid && rt_sel_pci && rt_unit == U_PCI)
        else $error("reserved hub cycle not passed to PCI");
    AST_PCI_MEDIUM: assert property (@(posedge clk_sys) disable iff (!reset_n)
        io_valid && io_src == SRC_PCI && dec_bus.hit |=> rt_valid && rt_claim_medium)
        else $error("PCI master fixed cycle not claimed at medium speed");
    AST_NO_DECODE: assert property (@(posedge clk_sys) disable iff (!reset_n)
        io_valid && io_src == SRC_PCI && !dec_bus.hit && !var_hit |=> !rt_valid)
        else $error("undecoded address claimed");
    AST_DMA_WO: assert property (@(posedge clk_sys) disable iff (!reset_n)
        io_valid && io_addr == 16'h0009 |=> rt_unit == (rt_write ? U_DMA : U_PCI) || !rt_valid)
        else $error("write-only DMA location misrouted");
    AST_TMR: assert property (@(posedge clk_sys) disable iff (!reset_n)
        io_valid && io_addr == 16'h0051 |=> rt_valid && rt_unit == U_TMR && rt_sel_int)
        else $error("timer location misrouted");
    AST_NMI_ODD: assert property (@(posedge clk_sys) disable iff (!reset_n)
        io_valid && io_addr[15:3] == 13'h000C && io_addr[0] |=> rt_unit == U_NMI)
        else $error("odd keyboard page location not sent to NMI logic");
    AST_RTC_BOTH: assert property (@(posedge clk_sys) disable iff (!reset_n)
        io_valid && io_write && io_addr == 16'h0072 |=> rt_unit == U_NMI_RTC && rt_sel_int)
        else $error("clock index write did not reach both units");
    AST_ONE_SEL: assert property (@(posedge clk_sys) disable iff (!reset_n)
        rt_valid == $onehot({rt_sel_int, rt_sel_lpc, rt_sel_pci}) &&
        (rt_valid || !(rt_sel_int || rt_sel_lpc || rt_sel_pci)))
        else $error("target selects not one-hot");

    COV_HUB_PASS: cover property (@(posedge clk_sys) disable iff (!reset_n)
        rt_valid && rt_sel_pci);
    COV_PCI_CLAIM: cover property (@(posedge clk_sys) disable iff (!reset_n)
        rt_valid && rt_claim_medium);
    COV_VAR_HIT: cover property (@(posedge clk_sys) disable iff (!reset_n)
        io_valid && var_hit);
    COV_W1C: cover property (@(posedge clk_sys) disable iff (!reset_n)
        wr_stat && stat_ff != STAT_RESET);

endmodule
`default_nettype wire

/* fio_router_tb.sv */
// Self-checking bench of the fixed I/O decode router
`timescale 1ns/1ps
`default_nettype none
module fio_router_tb;
    import fio_pkg::*;
    logic clk_sys = 1'b0;
    logic reset_n = 1'b0;
    logic lan_present = 1'b1;
    logic [5:0] func_disable = 6'h00;
    logic io_valid, io_write, cfg_valid, cfg_write, rt_valid, rt_write, cfg_done, cfg_claim;
    logic rt_sel_int, rt_sel_lpc, rt_sel_pci, rt_claim_medium;
    logic [15:0] io_addr, rt_addr;
    logic [7:0] io_wdata, rt_wdata, cfg_bus, cfg_reg;
    logic [4:0] cfg_dev;
    logic [2:0] cfg_func;
    logic [31:0] cfg_wdata, cfg_rdata;
    fio_src_t io_src;
    fio_unit_t rt_unit;
    int err_total, checked, cnt, stat, wbase, pa, pd, pdat;
    int pu = -1;
    bit wen, pw, ps, pc, pcl;
    // Clock at 40 MHz
    always #12.5 clk_sys = ~clk_sys;
    fio_router uut (.clk_sys, .reset_n, .io_valid, .io_src, .io_write, .io_addr, .io_wdata,
        .rt_valid, .rt_unit, .rt_sel_int, .rt_sel_lpc, .rt_sel_pci, .rt_claim_medium, .rt_write,
        .rt_addr, .rt_wdata, .cfg_valid, .cfg_write, .cfg_bus, .cfg_dev, .cfg_func, .cfg_reg,
        .cfg_wdata, .cfg_done, .cfg_claim, .cfg_rdata, .func_disable, .lan_present);
    fio_host_model host (.clk_sys, .io_valid, .io_src, .io_write, .io_addr, .io_wdata,
        .cfg_valid, .cfg_write, .cfg_bus, .cfg_dev, .cfg_func, .cfg_reg, .cfg_wdata);
    ////////////////////////////////////////////////////////////////////////////
    // Compare and count
    task automatic check(input string n, input logic [31:0] seen, input logic [31:0] want);
        checked++;
        if (seen !== want) begin
            err_total++;
            $display("unexpected %s: expected %h, seen %h", n, want, seen);
        end
    endtask
    // Print counts and verdict
    task automatic conclude();
        $display("checks %0d mismatches %0d", checked, err_total);
        if (err_total == 0 && checked > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask
    // Fixed map: unit, -1 undecoded, -2 reserved for this direction
    function automatic int fixed(input int a, input bit w);
        if (a > 32'h74) return -1;
        if (a <= 32'h08 || a == 32'h0F || a inside {[32'h10:32'h18]} || a == 32'h1F) return U_DMA;
        if (a < 32'h20) return w ? U_DMA : -2;
        if (a inside {32'h2E, 32'h2F, 32'h4E, 32'h4F}) return U_LPC;
        if (a < 32'h3E) return a[1] ? -1 : U_INTC;
        if (a inside {[32'h40:32'h42], [32'h50:32'h52]}) return U_TMR;
        if (a inside {32'h43, 32'h53}) return w ? U_TMR : -2;
        if (a inside {[32'h60:32'h67]}) return a[0] ? U_NMI : U_LPC;
        if (a inside {32'h71, 32'h73}) return U_RTC;
        if (a inside {32'h70, 32'h72, 32'h74}) return w ? U_NMI_RTC : (a == 32'h70 ? -2 : U_RTC);
        return -1;
    endfunction
    // One slot: check the previous slot's results, then model this one
    task automatic step(input bit iv, input bit s, input bit w, input int a, input bit cv,
        input bit cw, input int cb, input int cdv, input int cf, input int cr, input int wd);
        int u;
        int d;
        bit pr;
        bit l;
        d = $urandom % 256;
        host.drive(iv, fio_src_t'(s), w, a[15:0], d[7:0], cv, cw, cb[7:0], cdv[4:0], cf[2:0],
            cr[7:0], wd);
        check("rt_valid", rt_valid, pu >= 0);
        check("rt_sel", {rt_sel_int, rt_sel_lpc, rt_sel_pci, rt_claim_medium}, pu < 0 ? 0 :
            {pu != U_LPC && pu != U_PCI, pu == U_LPC, pu == U_PCI, ps});
        if (pu >= 0) check("rt_unit", rt_unit, pu);
        if (pu >= 0) check("rt_copy", {rt_write, rt_addr, rt_wdata}, {pw, pa[15:0], pw ? pd[7:0] : 8'h00});
        check("cfg_done", cfg_done, pc);
        if (pc) check("cfg_claim", cfg_claim, pcl);
        if (pc) check("cfg_rdata", cfg_rdata, pdat);
        u = fixed(a, w);
        if (u < 0 && wen && a[15:4] == wbase) u = U_LPC;
        if (iv && u == -2) stat |= !s;
        if (iv && u == -1) stat |= 2;
        if (u < 0) u = s ? -1 : U_PCI;
        if (iv && u >= 0 && u != U_LPC && u != U_PCI) cnt++;
        pu = iv ? u : -1;
        {pa, pd, pw, ps} = {a, d, w, s};
        pr = (cb == 0 && cdv == 32'h1E && cf == 0) || (cb == 1 && cdv == 8 && cf == 0 && lan_present)
            || (cb == 0 && cdv == 32'h1F && (cf == 0 || cf < 7 && !func_disable[cf - 1]));
        l = pr && cb == 0 && cdv == 32'h1F && cf == 0;
        {pc, pcl} = {cv, pr};
        pdat = cw ? 0 : !pr ? 32'hFFFFFFFF : cr == 0 ? {ID_DEVICE_HI, cdv[4:0], cf[2:0], ID_VENDOR} :
            !l ? 0 : cr == 32'h40 ? stat : cr == 32'h44 ? cnt & 32'h0000FFFF : 0;
        if (cv && cw && l && cr == 32'h40) stat &= ~wd;
        if (cv && cw && l && cr == 32'h44) {wen, wbase} = {wd[0], 32'(wd[15:4])};
    endtask
    task automatic io(input bit iv, input bit s, input bit w, input int a);
        step(iv, s, w, a, 0, 0, 0, 0, 0, 0, 0);
    endtask
    task automatic cfg(input bit cw, input int cb, input int cdv, input int cf, input int cr,
        input int wd);
        io(0, 0, 0, 0);
        step(0, 0, 0, 0, 1, cw, cb, cdv, cf, cr, wd);
    endtask
    ////////////////////////////////////////////////////////////////////////////
    // Main sequence
    initial begin
        void'($urandom(23));
        repeat (6) @(negedge clk_sys);
        reset_n = 1'b1;
        repeat (3) io(0, 0, 0, 0);
        cfg(0, 0, 32'h1F, 0, 32'h40, 0);
        cfg(0, 0, 32'h1F, 0, 32'h44, 0);
        for (int a = 0; a < 32'h80; a++) begin
            for (int k = 0; k < 4; k++) io(1, k[1], k[0], a);
        end
        for (int t = 0; t < 4; t++) begin
            func_disable = 6'($urandom);
            lan_present = t[0];
            repeat (3) io(0, 0, 0, 0);
            for (int f = 0; f < 8; f++) begin
                cfg(0, 0, 32'h1F, f, 0, 0);
                cfg(0, 0, 32'h1E, f, 0, 0);
                cfg(0, t[1], 8, f, 0, 0);
            end
        end
        cfg(1, 0, 32'h1F, 0, 32'h40, 3);
        io(1, 0, 0, 32'h09);
        io(1, 1, 1, 32'h7F);
        for (int v = 1; v < 4; v++) begin
            cfg(0, 0, 32'h1F, 0, 32'h40, 0);
            cfg(1, 0, 32'h1F, 0, 32'h40, v);
        end
        cfg(0, 0, 32'h1F, 0, 32'h40, 0);
        cfg(1, 0, 32'h1F, 0, 32'h44, 32'h0301);
        cfg(0, 0, 32'h1F, 0, 32'h44, 0);
        repeat (400) io($urandom % 5 != 0, $urandom % 2, $urandom % 2, $urandom % 4 == 0 ?
            32'h0300 + $urandom % 32 : $urandom % 32'h80);
        cfg(0, 0, 32'h1F, 0, 32'h44, 0);
        cfg(0, 0, 32'h1F, 0, 32'h40, 0);
        io(0, 0, 0, 0);
        reset_n = 1'b0;
        {cnt, stat, wen} = {32'h0, 32'h0, 1'b0};
        repeat (2) @(negedge clk_sys);
        reset_n = 1'b1;
        cfg(0, 0, 32'h1F, 0, 32'h40, 0);
        cfg(0, 0, 32'h1F, 0, 32'h44, 0);
        io(1, 0, 0, 32'h0305);
        io(0, 0, 0, 0);
        conclude();
    end
    // Watchdog sized well beyond the expected run
    initial begin
        #(25 * 4000);
        err_total++;
        conclude();
    end
endmodule
`default_nettype wire
